// ---- logic/tlsc_shuttle_ctrl.sv ----
// Low-tape stop, shuttle mode and shuttle point entry for the tape transport
// Notes on behaviour
// - Command stop when a reel pack shrinks to about a quarter inch.
// - Low-tape mode lights its indicator and stops at both tape ends outside shuttle and track modes.
// - Driving forward stops near supply empty even unselected, unless jumper out.
// - Low key while lit selects not-low-tape; jumper decides which reel may unspool.
// - Shuttle or track sequence selection deactivates low-tape mode.
// - In transport sequence mode the low-tape event starts a chained recorder.
// - Entering calibrate selects low-tape mode; the low key still leaves it.
// - Low key toggles low-tape; any sequence or shuttle selection exits it.
// - Not low-tape: jumper in stops at supply end only, out ignores both.
// - Shuttle mode drives back and forth between two end points.
// - Points typed or captured from footage, moving or stopped, shown anytime.
// - Shuttle key lights shuttle indicator and overrides the other modes.
// - Low, track or transport sequence key leaves shuttle mode.
// - Set key flashes shuttle indicator; speed keys become digits, echoed.
// - Forward stores low point, reverse high point; display returns to footage.
// - Reel-limit stop beats a shuttle point lying beyond it.
// - Keyboard entry with preset reel-limit switch flashes L for five seconds.
// - Stop during entry discards digits and abandons entry.
// - Display then set key shows a point while its direction key is held.
// - Points change only by new entries, bus writes or power-up restore; presets override stored points.
// - Reverse-end switch selects high-end turnaround or stop behaviour.
// - Forward-end switch selects low-end turnaround or stop behaviour.
// - Low-tape state, shuttle mode, points and footage restore at power-up.
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "tlsc_defines.svh"
module tlsc_shuttle_ctrl #(
    parameter int unsigned L_CYC     = `TLSC_L_FLASH_S * `TLSC_CLK_MHZ * 1000000,
    parameter int unsigned BLINK_CYC = `TLSC_BLINK_MS * `TLSC_CLK_MHZ * 1000
) (
    input  wire logic                    mclk,
    input  wire logic                    reset_n,
    input  wire tlsc_pkg::tlsc_panel_t   panel_pins,
    input  wire logic [15:0]             footage,
    input  wire logic                    footage_upd,
    input  wire logic                    moving_fwd,
    input  wire logic                    moving_rev,
    input  wire tlsc_pkg::tlsc_nv_t      nv_restore,
    input  wire logic                    nv_load,
    input  wire logic [3:0]              reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [31:0]                  reg_rdata,
    output tlsc_pkg::tlsc_drive_t        drive_cmd,
    output logic                         low_limit_indicator,
    output logic                         shuttle_indicator,
    output logic                         speed_keys_as_digits,
    output logic                         chain_start,
    output logic [15:0]                  counter_value,
    output logic                         counter_shows_l,
    output tlsc_pkg::tlsc_nv_t           nv_image
);
    import tlsc_pkg::*;

    localparam int unsigned CW = `TLSC_CNT_W;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    tlsc_panel_t sync1;
    tlsc_panel_t pin;
    tlsc_panel_t pin_q;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sync1 <= '0;
            pin   <= '0;
            pin_q <= '0;
        end else begin
            sync1 <= panel_pins;
            pin   <= sync1;
            pin_q <= pin;
        end
    end

    wire p_low  = pin.low_limit_key & ~pin_q.low_limit_key;
    wire p_shuttle_key = pin.shuttle_key & ~pin_q.shuttle_key;
    wire p_set  = pin.shuttle_set_key & ~pin_q.shuttle_set_key;
    wire p_trk  = pin.track_sequence_key & ~pin_q.track_sequence_key;
    wire p_xseq = pin.transport_sequence_key & ~pin_q.transport_sequence_key;
    wire p_display_key = pin.display_key & ~pin_q.display_key;
    wire p_fwd  = pin.fwd_key & ~pin_q.fwd_key;
    wire p_rev  = pin.rev_key & ~pin_q.rev_key;
    wire p_stop = pin.stop_key & ~pin_q.stop_key;
    wire p_dig  = pin.digit_key & ~pin_q.digit_key & (pin.digit <= `TLSC_DIGIT_MAX);
    wire r_dir  = (~pin.fwd_key & pin_q.fwd_key) | (~pin.rev_key & pin_q.rev_key);
    wire cal_up = pin.cal_mode & ~pin_q.cal_mode;
    wire any_p  = p_low | p_shuttle_key | p_trk | p_xseq | p_fwd | p_rev | p_stop | p_dig;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    tlsc_mode_t  mode;
    tlsc_entry_t entry;
    tlsc_entry_t next_entry;
    logic [15:0] low_pt;
    logic [15:0] high_pt;
    logic [15:0] foot_r;
    logic [15:0] accum;
    logic        have_dig;
    logic        lt_ev_q;
    logic        blink;
    logic [CW-1:0] blink_cnt;
    logic [CW-1:0] l_cnt;

    // Out-of-range switch codes fall back to plain stored-point shuttling
    wire [2:0] rsw_raw = pin.reverse_end_preset_switch;
    wire [2:0] fsw_raw = pin.forward_end_preset_switch;
    wire tlsc_preset_t rsw = tlsc_preset_t'((rsw_raw > 3'h4) ? 3'h0 : rsw_raw);
    wire tlsc_preset_t fsw = tlsc_preset_t'((fsw_raw > 3'h4) ? 3'h0 : fsw_raw);
    wire rev_lim = (rsw == drive_at_reel_limit) | (rsw == fast_at_reel_limit);
    wire fwd_lim = (fsw == drive_at_reel_limit) | (fsw == fast_at_reel_limit);
    wire preset_lim = rev_lim | fwd_lim;

    // ------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------
    wire next_low_sel = (p_shuttle_key | p_trk | p_xseq) ? 1'b0 :
                        p_low  ? ~low_limit_indicator :
                        cal_up ? 1'b1 :
                        low_limit_indicator;
    wire tlsc_mode_t next_mode = p_shuttle_key ? mode_shuttle :
                                 p_trk  ? mode_track :
                                 p_xseq ? mode_xseq :
                                 p_low  ? mode_none :
                                 mode;

    // Track sequence rides on the shuttle machinery
    wire shuttling = (mode == mode_shuttle) | (mode == mode_track);

    // ------------------------------------------------------------
    // Transport decisions
    // ------------------------------------------------------------
    wire eot_hit = moving_fwd & pin.supply_low;
    wire bot_hit = moving_rev & pin.takeup_low;
    wire jmp_in  = pin.unspool_override_jumper;
    wire lt_stop = low_limit_indicator ? (eot_hit | bot_hit) :
                   jmp_in ? eot_hit : 1'b0;
    wire foot_hi = footage_upd & moving_fwd & (footage >= high_pt);
    wire foot_lo = footage_upd & moving_rev & (footage <= low_pt);

    // High end: reel limit turnaround or stored point action
    wire hi_turn = rev_lim ? eot_hit : foot_hi & (rsw != halt_at_stored_point);
    wire hi_fast = (rsw == fast_at_reel_limit) | (rsw == fast_at_stored_point);
    wire hi_halt = (rev_lim ? 1'b0 : eot_hit) |
                   (foot_hi & (rsw == halt_at_stored_point));
    wire lo_turn = fwd_lim ? bot_hit : foot_lo & (fsw != halt_at_stored_point);
    wire lo_fast = (fsw == fast_at_reel_limit) | (fsw == fast_at_stored_point);
    wire lo_halt = (fwd_lim ? 1'b0 : bot_hit) |
                   (foot_lo & (fsw == halt_at_stored_point));

    tlsc_drive_t next_drive;
    always_comb begin
        next_drive = '0;
        if (shuttling) begin
            if (hi_halt | lo_halt) begin
                next_drive.stop = 1'b1;
            end else if (hi_turn) begin
                next_drive.rev  = 1'b1;
                next_drive.fast = hi_fast;
            end else if (lo_turn) begin
                next_drive.fwd  = 1'b1;
                next_drive.fast = lo_fast;
            end
        end else begin
            next_drive.stop = lt_stop;
        end
    end

    wire lt_ev = eot_hit | bot_hit;
    wire next_chain = (mode == mode_xseq) & lt_ev & ~lt_ev_q;

    // ------------------------------------------------------------
    // Point entry and display sequencing
    // ------------------------------------------------------------
    wire [15:0] acc_x10 = 16'((accum << 3) + (accum << 1));
    wire [15:0] acc_dig = 16'(acc_x10 + {12'h000, pin.digit});
    // With no digits typed the live footage is captured instead
    wire [15:0] new_pt  = have_dig ? accum : foot_r;
    wire keys_ok = (entry == ent_keys) & ~p_stop;
    wire st_low  = keys_ok & p_fwd;
    wire st_high = keys_ok & ~p_fwd & p_rev;
    wire l_start = (entry == ent_idle) & ~p_display_key & p_set & preset_lim;

    always_comb begin
        next_entry = entry;
        case (entry)
            ent_idle: begin
                if (p_display_key) begin
                    next_entry = ent_arm;
                end else if (p_set & ~preset_lim) begin
                    next_entry = ent_keys;
                end
            end
            ent_keys: begin
                if (p_stop | p_fwd | p_rev) begin
                    next_entry = ent_idle;
                end
            end
            ent_arm: begin
                if (p_set) begin
                    next_entry = ent_show;
                end else if (any_p | p_display_key) begin
                    next_entry = ent_idle;
                end
            end
            ent_show: begin
                if (r_dir | p_stop) begin
                    next_entry = ent_idle;
                end
            end
            default: begin
                next_entry = ent_idle;
            end
        endcase
    end

    wire [15:0] next_counter = (entry == ent_keys) ? accum :
                               (entry == ent_show & pin.fwd_key) ? low_pt :
                               (entry == ent_show & pin.rev_key) ? high_pt :
                               (l_cnt != '0) ? 16'h0000 :
                               foot_r;

    wire blink_wrap = (blink_cnt == CW'(BLINK_CYC - 1));

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    wire wr_low  = reg_wr & (reg_addr == `TLSC_A_LOW_POINT);
    wire wr_high = reg_wr & (reg_addr == `TLSC_A_HIGH_POINT);
    wire [31:0] status_word = {20'h0_0000, preset_lim, entry, mode,
                               shuttling, lt_stop, low_limit_indicator};
    wire [31:0] rd_mux = (reg_addr == `TLSC_A_STATUS)     ? status_word :
                         (reg_addr == `TLSC_A_LOW_POINT)  ? {16'h0000, low_pt} :
                         (reg_addr == `TLSC_A_HIGH_POINT) ? {16'h0000, high_pt} :
                         32'h0000_0000;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            low_limit_indicator <= 1'b0;
            mode                <= mode_none;
        end else if (nv_load) begin
            low_limit_indicator <= nv_restore.low_sel;
            mode <= nv_restore.shuttle ? mode_shuttle : mode_none;
        end else begin
            low_limit_indicator <= next_low_sel;
            mode                <= next_mode;
        end
    end

    // Keyboard entry wins over a bus write in the same cycle
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            low_pt  <= `TLSC_POINT_RST;
            high_pt <= `TLSC_POINT_RST;
        end else if (nv_load) begin
            low_pt  <= nv_restore.low_pt;
            high_pt <= nv_restore.high_pt;
        end else begin
            low_pt  <= st_low ? new_pt : wr_low ? reg_wdata[15:0] : low_pt;
            high_pt <= st_high ? new_pt : wr_high ? reg_wdata[15:0] : high_pt;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            foot_r <= `TLSC_POINT_RST;
        end else if (nv_load) begin
            foot_r <= nv_restore.footage;
        end else if (footage_upd) begin
            foot_r <= footage;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            entry    <= ent_idle;
            accum    <= 16'h0000;
            have_dig <= 1'b0;
        end else begin
            entry    <= next_entry;
            accum    <= (next_entry != ent_keys) ? 16'h0000 : p_dig ? acc_dig : accum;
            have_dig <= (next_entry == ent_keys) & (have_dig | p_dig);
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            l_cnt     <= '0;
            blink_cnt <= '0;
            blink     <= 1'b0;
        end else begin
            l_cnt     <= l_start ? CW'(L_CYC) : (l_cnt != '0) ? CW'(l_cnt - 1'b1) : l_cnt;
            blink_cnt <= blink_wrap ? '0 : CW'(blink_cnt + 1'b1);
            blink     <= blink_wrap ? ~blink : blink;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            drive_cmd            <= '0;
            lt_ev_q              <= 1'b0;
            chain_start          <= 1'b0;
            shuttle_indicator    <= 1'b0;
            speed_keys_as_digits <= 1'b0;
            counter_value        <= 16'h0000;
            counter_shows_l      <= 1'b0;
            nv_image             <= '0;
            reg_rdata            <= 32'h0000_0000;
        end else begin
            drive_cmd            <= next_drive;
            lt_ev_q              <= lt_ev;
            chain_start          <= next_chain;
            shuttle_indicator    <= (next_entry == ent_keys) ? blink : (next_mode == mode_shuttle);
            speed_keys_as_digits <= (next_entry == ent_keys);
            counter_value        <= next_counter;
            counter_shows_l      <= (l_cnt != '0) & blink;
            nv_image             <= '{low_sel: low_limit_indicator, shuttle: (mode == mode_shuttle),
                                      low_pt: low_pt, high_pt: high_pt, footage: foot_r};
            reg_rdata            <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_low_both_ends: assert property (@(posedge mclk) disable iff (!reset_n)
        !shuttling && low_limit_indicator && (eot_hit || bot_hit) |=> drive_cmd.stop)
        else $error("low-tape mode did not stop at a tape end");
    chk_jumper_eot: assert property (@(posedge mclk) disable iff (!reset_n)
        !shuttling && !low_limit_indicator && jmp_in && eot_hit |=> drive_cmd.stop)
        else $error("forward supply-end stop missing with jumper in");
    chk_jumper_free: assert property (@(posedge mclk) disable iff (!reset_n)
        !shuttling && !low_limit_indicator && !jmp_in |=> !drive_cmd.stop)
        else $error("stop issued with jumper out and low-tape off");
    chk_shuttle_entry: assert property (@(posedge mclk) disable iff (!reset_n)
        p_shuttle_key && !nv_load |=> mode == mode_shuttle && !low_limit_indicator ##1 shuttle_indicator || entry == ent_keys)
        else $error("shuttle key did not take over");
    chk_low_key_exit: assert property (@(posedge mclk) disable iff (!reset_n)
        p_low && !p_shuttle_key && !p_trk && !p_xseq && !nv_load |=>
        mode == mode_none && low_limit_indicator == !$past(low_limit_indicator))
        else $error("low key did not leave sequence modes");
    chk_chain_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
        mode == mode_xseq && lt_ev && !lt_ev_q |=> chain_start ##1 !chain_start)
        else $error("chained start pulse wrong");
    chk_low_store: assert property (@(posedge mclk) disable iff (!reset_n)
        st_low && have_dig && !nv_load |=> low_pt == $past(accum) && entry == ent_idle)
        else $error("forward key did not store low point");
    chk_stop_discard: assert property (@(posedge mclk) disable iff (!reset_n)
        entry == ent_keys && p_stop && !reg_wr && !nv_load |=> entry == ent_idle && $stable(low_pt) && $stable(high_pt))
        else $error("stop during entry changed a point");
    chk_l_timer: assert property (@(posedge mclk) disable iff (!reset_n)
        l_start |=> l_cnt == CW'(L_CYC) && entry == ent_idle)
        else $error("letter L timer not started");
    chk_cal_low: assert property (@(posedge mclk) disable iff (!reset_n)
        cal_up && !p_low && !p_shuttle_key && !p_trk && !p_xseq && !nv_load |=> low_limit_indicator)
        else $error("calibrate did not select low-tape");
    chk_rev_point: assert property (@(posedge mclk) disable iff (!reset_n)
        shuttling && rsw == drive_at_stored_point && foot_hi && !eot_hit && !bot_hit |=> drive_cmd.rev && !drive_cmd.fast)
        else $error("high point did not reverse");
    chk_fwd_fast: assert property (@(posedge mclk) disable iff (!reset_n)
        shuttling && fsw == fast_at_stored_point && foot_lo && !eot_hit && !bot_hit |=> drive_cmd.fwd && drive_cmd.fast)
        else $error("low point did not fast forward");
    chk_limit_wins: assert property (@(posedge mclk) disable iff (!reset_n)
        shuttling && eot_hit && !rev_lim |=> drive_cmd.stop && !drive_cmd.rev)
        else $error("reel limit did not override shuttle");
    chk_show_low: assert property (@(posedge mclk) disable iff (!reset_n)
        entry == ent_show && pin.fwd_key |=> counter_value == $past(low_pt))
        else $error("held forward key did not show low point");
endmodule // tlsc_shuttle_ctrl

// ---- logic/tlsc_defines.svh ----
// Constants for the tape low-limit and shuttle control block
`ifndef TLSC_DEFINES_SVH
`define TLSC_DEFINES_SVH
`define TLSC_FOOT_W 16
`define TLSC_CNT_W 29
`define TLSC_A_STATUS 4'h0
`define TLSC_A_LOW_POINT 4'h4
`define TLSC_A_HIGH_POINT 4'h8
`define TLSC_POINT_RST 16'h0000
`define TLSC_CLK_MHZ 100
`define TLSC_L_FLASH_S 5
`define TLSC_BLINK_MS 250
`define TLSC_DIGIT_MAX 4'h9
`endif

// ---- logic/tlsc_pkg.sv ----
// Types shared by the tape low-limit and shuttle control block
package tlsc_pkg;
`include "tlsc_defines.svh"
    typedef struct packed {
        logic       low_limit_key;
        logic       shuttle_key;
        logic       shuttle_set_key;
        logic       track_sequence_key;
        logic       transport_sequence_key;
        logic       display_key;
        logic       fwd_key;
        logic       rev_key;
        logic       stop_key;
        logic       digit_key;
        logic [3:0] digit;
        logic       supply_low;
        logic       takeup_low;
        logic       unspool_override_jumper;
        logic       cal_mode;
        logic [2:0] reverse_end_preset_switch;
        logic [2:0] forward_end_preset_switch;
    } tlsc_panel_t;
    typedef struct packed {
        logic stop;
        logic fwd;
        logic rev;
        logic fast;
    } tlsc_drive_t;
    typedef struct packed {
        logic                     low_sel;
        logic                     shuttle;
        logic [`TLSC_FOOT_W-1:0] low_pt;
        logic [`TLSC_FOOT_W-1:0] high_pt;
        logic [`TLSC_FOOT_W-1:0] footage;
    } tlsc_nv_t;
    typedef enum logic [2:0] {
        drive_at_stored_point = 3'h0,
        drive_at_reel_limit   = 3'h1,
        fast_at_reel_limit    = 3'h2,
        fast_at_stored_point  = 3'h3,
        halt_at_stored_point  = 3'h4
    } tlsc_preset_t;
    typedef enum logic [3:0] {
        mode_none    = 4'h1,
        mode_shuttle = 4'h2,
        mode_track   = 4'h4,
        mode_xseq    = 4'h8
    } tlsc_mode_t;
    typedef enum logic [3:0] {
        ent_idle = 4'h1,
        ent_keys = 4'h2,
        ent_arm  = 4'h4,
        ent_show = 4'h8
    } tlsc_entry_t;
endpackage

// ---- tb/tlsc_transport_model.sv ----
// Behavioural tape transport that runs on bench command and obeys the stop and reverse bits of the block's drive command
`timescale 1ns/10ps
module tlsc_transport_model (
    input  wire logic                  mclk,
    input  wire logic                  reset_n,
    input  wire logic                  run_fwd,
    input  wire tlsc_pkg::tlsc_drive_t drive_cmd,
    output logic [15:0]                footage,
    output logic                       footage_upd,
    output logic                       moving_fwd,
    output logic                       moving_rev
);
    import tlsc_pkg::*;
    logic halted;
    assign moving_fwd = run_fwd & ~halted & ~drive_cmd.rev;
    assign moving_rev = run_fwd & ~halted & drive_cmd.rev;
    // A stop holds until the run request drops, so the cause vanishes and the block must not re-stop
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            halted      <= 1'b0;
            footage     <= 16'h0000;
            footage_upd <= 1'b0;
        end else begin
            halted      <= run_fwd & (halted | drive_cmd.stop);
            footage_upd <= moving_fwd | moving_rev;
            footage     <= footage + {15'h0000, moving_fwd} - {15'h0000, moving_rev};
        end
    end
endmodule // tlsc_transport_model

// ---- tb/tlsc_shuttle_ctrl_tb_top.sv ----
// Self-checking bench for the tape low-limit and shuttle control block
`timescale 1ns/10ps
module tlsc_shuttle_ctrl_tb_top;
    import tlsc_pkg::*;
    logic        mclk, reset_n, upd, mv_f, mv_r, run_fwd, rr, rw, lo, sh, dm, sl, cs, ld;
    logic [3:0]  seen;
    tlsc_nv_t    nv, nvr;
    tlsc_panel_t panel;
    tlsc_drive_t drv;
    logic [15:0] foot, cv;
    logic [3:0]  ra;
    logic [31:0] rdata, wd;
    int          err_total, total_checks, cyc;

    tlsc_shuttle_ctrl #(.L_CYC(40), .BLINK_CYC(4)) u_tlsc_shuttle_ctrl (.mclk(mclk), .reset_n(reset_n),
        .panel_pins(panel), .footage(foot), .footage_upd(upd), .moving_fwd(mv_f), .moving_rev(mv_r),
        .nv_restore(nvr), .nv_load(ld), .reg_addr(ra), .reg_wdata(wd), .reg_wr(rw), .reg_rd(rr),
        .reg_rdata(rdata), .drive_cmd(drv), .low_limit_indicator(lo), .shuttle_indicator(sh),
        .speed_keys_as_digits(dm), .chain_start(cs), .counter_value(cv), .counter_shows_l(sl), .nv_image(nv));
    tlsc_transport_model u_tlsc_transport_model (.mclk(mclk), .reset_n(reset_n), .run_fwd(run_fwd),
        .drive_cmd(drv), .footage(foot), .footage_upd(upd), .moving_fwd(mv_f), .moving_rev(mv_r));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Stop, reverse, chain and letter pulses can be a single cycle long, so remember any of them
    always @(posedge mclk) begin
        if (drv.stop === 1'b1) seen[0] <= 1'b1;
        if (cs === 1'b1) seen[1] <= 1'b1;
        if (drv.rev === 1'b1) seen[2] <= 1'b1;
        if (sl === 1'b1) seen[3] <= 1'b1;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            end_of_test();
        end
    end

    task automatic end_of_test;
        $display("Checks %0d, errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        #1;
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Keys pass a two-flop synchroniser and an edge detector, so hold and settle six cycles each way
    task automatic press(input int b);
        @(posedge mclk);
        panel[b] <= 1'b1;
        repeat (6) @(posedge mclk);
        panel[b] <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask
    task automatic dig(input logic [3:0] d);
        panel.digit <= d;
        press(14);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk);
        ra <= a;
        rr <= 1'b1;
        @(posedge mclk);
        rr <= 1'b0;
        // Read data are launched at this edge; look once they have settled
        @(negedge mclk);
        chk(rdata, exp);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        ra <= a;
        wd <= d;
        rw <= 1'b1;
        @(posedge mclk);
        rw <= 1'b0;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {reset_n, run_fwd, rr, rw, ld, seen, panel, ra, wd, nvr} = '0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        chk(32'({lo, sh, dm, drv}), 32'h0000_0000);
        press(23);
        rd(4'h0, 32'h0000_0089);
        for (int k = 0; k < 4; k++) begin
            if (k % 2 == 1) press((k == 1) ? 23 : 19);
            panel[7] <= (k != 2);
            seen = '0;
            chk(32'(lo), 32'(k == 0));
            run_fwd <= 1'b1;
            panel[9] <= 1'b1;
            repeat (8) @(posedge mclk);
            chk(32'(seen[0]), 32'(k != 2));
            chk(32'(seen[1]), 32'(k == 3));
            run_fwd <= 1'b0;
            panel[9] <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        press(23);
        press(22);
        chk(32'({sh, lo}), 32'h0000_0002);
        press(23);
        chk(32'({sh, lo}), 32'h0000_0001);
        press(22);
        press(20);
        panel[6] <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(32'(lo), 32'h0000_0001);
        chk(32'(sh), 32'h0000_0000);
        press(21);
        dig(4'h1);
        dig(4'h0);
        dig(4'h0);
        dig(4'h0);
        chk(32'({dm, cv}), 32'h0001_03E8);
        press(17);
        chk(32'(dm), 32'h0000_0000);
        rd(4'h4, 32'h0000_03E8);
        press(21);
        dig(4'h5);
        press(15);
        chk(32'(dm), 32'h0000_0000);
        rd(4'h4, 32'h0000_03E8);
        wr(4'h8, 32'h0000_07D0);
        rd(4'h8, 32'h0000_07D0);
        rd(4'hC, 32'h0000_0000);
        for (int j = 0; j < 2; j++) begin
            press(18);
            press(21);
            panel[16 + j] <= 1'b1;
            repeat (6) @(posedge mclk);
            chk(32'(cv), (j == 0) ? 32'h0000_07D0 : 32'h0000_03E8);
            panel[16 + j] <= 1'b0;
        end
        panel.reverse_end_preset_switch <= 3'h1;
        seen = '0;
        press(21);
        chk(32'({seen[3], dm}), 32'h0000_0002);
        repeat (50) @(posedge mclk);
        chk(32'(sl), 32'h0000_0000);
        // Track mode shuttles; reverse end at the reel limit must turn, not stop
        seen = '0;
        run_fwd <= 1'b1;
        panel[9] <= 1'b1;
        repeat (8) @(posedge mclk);
        chk(32'(seen[2:0]), 32'h0000_0004);
        run_fwd <= 1'b0;
        panel[9] <= 1'b0;
        nvr <= '{low_sel: 1'b1, shuttle: 1'b1, low_pt: 16'h1234, high_pt: 16'h0ABC, footage: 16'h0055};
        repeat (4) @(posedge mclk);
        ld <= 1'b1;
        @(posedge mclk);
        ld <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(32'({lo, sh, cv}), 32'h0003_0055);
        chk(32'({nv.low_pt, nv.high_pt}), 32'h1234_0ABC);
        end_of_test();
    end
endmodule // tlsc_shuttle_ctrl_tb_top
